// ===== vcc_pkg.sv
// shared constants and types of the voice companding codec
// assumes one 100 MHz clock and a synchronous active-high reset
package vcc_pkg;

   // ---------------------------------------------------------------
   // widths and field layout
   // ---------------------------------------------------------------
   localparam int SMP_W = 13;             // linear sample width
   localparam int CODE_W = 8;             // companded code width
   localparam int SIGN_POS = 7;           // sign bit of a code
   localparam int SEG_HI = 6;             // segment field 6:4
   localparam int SEG_LO = 4;
   localparam int STEP_HI = 3;            // step field 3:0
   localparam int SEG_COUNT = 8;          // segment 0 plus seven above

   // ---------------------------------------------------------------
   // law coding constants
   // ---------------------------------------------------------------
   localparam logic [7:0] A_XOR = 8'h55;       // even-bit inversion on the line
   localparam logic [13:0] MU_BIAS = 14'h0021; // bias of 33 on the 14-bit scale
   localparam logic [13:0] MU_CLIP = 14'h1fde; // largest magnitude 8158
   localparam logic [12:0] A_SEG_OFS = 13'h0020;
   localparam logic [13:0] MU_SEG_OFS = 14'h0020;

   // ---------------------------------------------------------------
   // reset and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] WAKE_FRAMES = 2'h2;  // frames muted after power-up
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [12:0] LIN_RST = 13'h0000;

   // ---------------------------------------------------------------
   // state of the codec
   // ---------------------------------------------------------------
   typedef struct packed {
      logic fs_meta;
      logic fs_sync;
      logic fs_prev;
      logic law_meta;
      logic law_mu;
      logic pd_meta;
      logic pd_up;
      logic [1:0] wake;
      logic [7:0] tx_code;
      logic tx_valid;
      logic [12:0] rx_linear;
      logic rx_valid;
   } vcc_state_t;

endpackage

// ===== vcc_codec.sv
// voice companding codec: 13-bit linear to 8-bit code and back, once per frame
// assumes linear samples and received codes arrive on clk; pins are asynchronous
`timescale 1ns/1ps

module vcc_codec (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous pins: static law select and power-down, pulsed frame sync
   input wire logic law_select_pin,
   input wire logic power_down_input,
   input wire logic transmit_frame_sync,
   // sampling converter side
   input wire logic [vcc_pkg::SMP_W-1:0] tx_linear,
   output logic [vcc_pkg::SMP_W-1:0] rx_linear,
   output logic rx_valid,
   // serial pcm port side
   input wire logic [vcc_pkg::CODE_W-1:0] rx_code,
   output logic [vcc_pkg::CODE_W-1:0] tx_code,
   output logic tx_valid
);
   import vcc_pkg::*;

   // ---------------------------------------------------------------
   // companding functions
   // ---------------------------------------------------------------
   // a-law: ones' complement for negatives keeps the code symmetric
   function automatic logic [7:0] enc_alaw(input logic [12:0] x);
      logic [11:0] mag;
      logic [2:0] seg;
      logic [3:0] step;
      mag = x[12] ? ~x[11:0] : x[11:0];
      seg = 3'h0;
      for (int i = 1; i < SEG_COUNT; i++) begin
         if (mag[i+4]) seg = 3'(i);
      end
      step = 4'(mag >> ((seg == 3'h0) ? 3'h1 : seg));
      return {~x[12], seg, step} ^ A_XOR;
   endfunction

   // mu-law: the sample is doubled onto the 14-bit scale and clipped first,
   // so adding the bias can never carry past the top segment
   function automatic logic [7:0] enc_mulaw(input logic [12:0] x);
      logic [13:0] v;
      logic [13:0] b;
      logic [2:0] seg;
      logic [3:0] step;
      v = {x, 1'b0};
      v = x[12] ? 14'(-v) : v;
      if (v > MU_CLIP) v = MU_CLIP;
      b = 14'(v + MU_BIAS);
      seg = 3'h0;
      for (int i = 1; i < SEG_COUNT; i++) begin
         if (b[i+5]) seg = 3'(i);
      end
      step = 4'(b >> (4'(seg) + 4'h1));
      return ~{x[12], seg, step};
   endfunction

   // decoders return the middle of the step interval
   function automatic logic [12:0] dec_alaw(input logic [7:0] c);
      logic [7:0] t;
      logic [12:0] m;
      t = c ^ A_XOR;
      m = {8'h00, t[STEP_HI:0], 1'b1};
      if (t[SEG_HI:SEG_LO] != 3'h0) begin
         m = 13'((m + A_SEG_OFS) << (t[SEG_HI:SEG_LO] - 3'h1));
      end
      return t[SIGN_POS] ? m : 13'(-m);
   endfunction

   function automatic logic [12:0] dec_mulaw(input logic [7:0] c);
      logic [7:0] t;
      logic [13:0] m;
      t = ~c;
      m = {9'h000, t[STEP_HI:0], 1'b1};
      m = 14'((m + MU_SEG_OFS) << t[SEG_HI:SEG_LO]);
      m = 14'(m - MU_BIAS);
      m = t[SIGN_POS] ? 14'(-m) : m;
      return m[13:1];                                     // back to the 13-bit scale
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   vcc_state_t s_q;
   vcc_state_t s_d;
   logic fs_rise;
   logic run;

   // the edge flop clears to the idle low level of the pin, so reset makes no false edge
   assign fs_rise = s_q.fs_sync & ~s_q.fs_prev;
   // a frame edge is only used once the power-up mute has run out
   assign run = s_q.pd_up & (s_q.wake == WAKE_FRAMES);

   // next state: pins pass two flops, conversion on the frame edge
   always_comb begin
      s_d = s_q;
      s_d.fs_meta = transmit_frame_sync;
      s_d.fs_sync = s_q.fs_meta;
      s_d.fs_prev = s_q.fs_sync;
      s_d.law_meta = law_select_pin;
      s_d.law_mu = s_q.law_meta;
      s_d.pd_meta = power_down_input;
      s_d.pd_up = s_q.pd_meta;
      s_d.tx_valid = 1'b0;
      s_d.rx_valid = 1'b0;
      if (!s_q.pd_up) begin
         s_d.wake = 2'h0;
      end else if (fs_rise && !run) begin
         s_d.wake = 2'(s_q.wake + 2'h1);
      end
      if (fs_rise && run) begin
         s_d.tx_valid = 1'b1;
         s_d.rx_valid = 1'b1;
         // law is static, so one synchronised copy serves both paths
         s_d.tx_code = s_q.law_mu ? enc_mulaw(tx_linear) : enc_alaw(tx_linear);
         s_d.rx_linear = s_q.law_mu ? dec_mulaw(rx_code) : dec_alaw(rx_code);
      end
   end

   // register the whole state
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.tx_code <= CODE_RST;
         s_q.rx_linear <= LIN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx_code = s_q.tx_code;
   assign tx_valid = s_q.tx_valid;
   assign rx_linear = s_q.rx_linear;
   assign rx_valid = s_q.rx_valid;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // one pulse per frame edge; the pin pulse is several cycles wide, so a
   // broken edge detector would show up here as a run of pulses
   AST_ONE_PER_FRAME: assert property (tx_valid |=> !tx_valid [*2])
      else $error("more than one encode per frame edge");
   AST_RX_ONE_PER_FRAME: assert property (rx_valid |=> !rx_valid [*2])
      else $error("more than one decode per frame edge");
   AST_PAIRED: assert property (tx_valid == rx_valid)
      else $error("encode and decode out of step");
   AST_FROM_EDGE: assert property (tx_valid |-> $past(fs_rise) && $past(s_q.pd_up))
      else $error("code issued without a frame edge");

   // outputs move only with their valid pulse and hold through power-down
   AST_TX_HOLD: assert property (!tx_valid |-> $stable(tx_code))
      else $error("code changed without a conversion");
   AST_RX_HOLD: assert property (!rx_valid |-> $stable(rx_linear))
      else $error("linear output changed without a conversion");

   // power-down and the wake-up mute
   AST_PD_MUTE: assert property (!s_q.pd_up |=> !tx_valid)
      else $error("conversion while powered down");
   AST_RX_PD_MUTE: assert property (!s_q.pd_up |=> !rx_valid)
      else $error("decode while powered down");
   AST_WAKE: assert property ($rose(s_q.pd_up) |-> !tx_valid [*8])
      else $error("conversion right after power-up");
   AST_WAKE_RANGE: assert property (s_q.wake <= WAKE_FRAMES)
      else $error("wake counter ran past its limit");

   // encoder fixed points; the line sign bit is high for positive input under both laws
   AST_TX_SIGN: assert property (tx_valid |-> tx_code[SIGN_POS] != $past(tx_linear[12]))
      else $error("code sign bit wrong");
   AST_MU_ZERO: assert property (tx_valid && $past(s_q.law_mu)
      && $past(tx_linear) == 13'h0000 |-> tx_code == 8'hff)
      else $error("mu-law zero miscoded");
   AST_A_ZERO: assert property (tx_valid && !$past(s_q.law_mu)
      && $past(tx_linear) == 13'h0000 |-> tx_code == 8'hd5)
      else $error("a-law zero miscoded");
   AST_A_TOP: assert property (tx_valid && !$past(s_q.law_mu)
      && $past(tx_linear) == 13'h0fff |-> tx_code == 8'haa)
      else $error("a-law full scale miscoded");
   AST_MU_TOP: assert property (tx_valid && $past(s_q.law_mu)
      && $past(tx_linear) == 13'h0fff |-> tx_code == 8'h80)
      else $error("mu-law full scale miscoded");

   // decoder fixed points and sign handling
   AST_A_SIGN: assert property (rx_valid && !$past(s_q.law_mu)
      && $past(rx_code[7]) |-> !rx_linear[12])
      else $error("a-law decode sign wrong");
   AST_MU_SIGN: assert property (rx_valid && $past(s_q.law_mu)
      && $past(rx_code[7]) |-> !rx_linear[12])
      else $error("mu-law decode sign wrong");
   AST_A_MID: assert property (rx_valid && !$past(s_q.law_mu)
      && $past(rx_code) == 8'hd5 |-> rx_linear == 13'h0001)
      else $error("a-law decode not at step midpoint");
   AST_MU_MID: assert property (rx_valid && $past(s_q.law_mu)
      && $past(rx_code) == 8'hff |-> rx_linear == 13'h0000)
      else $error("mu-law decode of zero code wrong");

   // main scenarios: both laws, power-down, wake-up, back-to-back frames
   COV_MU_FRAME: cover property (tx_valid && $past(s_q.law_mu));
   COV_A_FRAME: cover property (tx_valid && !$past(s_q.law_mu));
   COV_POWER_DOWN: cover property (s_q.pd_up ##1 !s_q.pd_up);
   COV_WAKE_UP: cover property ($rose(s_q.pd_up) ##[1:1000] tx_valid);
   COV_NEXT_FRAME: cover property (tx_valid ##[3:100] tx_valid);

endmodule

// ===== vcc_frame_src.sv
// frame sync source standing in for the host side of the codec
// assumes fire is a one-cycle request driven off the sampling edge
`timescale 1ns/1ps

module vcc_frame_src (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request and sync pin
   input wire logic fire,
   output logic fsync
);
   logic [2:0] cnt_q;
   // held four cycles so the two-flop synchroniser cannot miss the pulse
   always_ff @(posedge clk) begin
      if (rst) cnt_q <= 3'h0;
      else if (fire) cnt_q <= 3'h4;
      else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
   end
   assign fsync = (cnt_q != 3'h0);
endmodule

// ===== voice_companding_codec_bench.sv
// bench: integer companding model compared with the codec every frame
// assumes vcc_pkg, vcc_codec and vcc_frame_src are compiled first
`timescale 1ns/1ps

module voice_companding_codec_bench;
   import vcc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, law = 1'b0, pwr = 1'b0, fire = 1'b0, fsync;
   logic [12:0] lin = 13'h0000, rx_lin;
   logic [7:0] code = 8'h00, tx_code;
   logic tx_valid, rx_valid;
   int error_cnt = 0, tests_run = 0, seed = 15;
   int dir[8] = '{0, -1, 31, 32, -33, 4095, -4096, 2048};
   logic [7:0] cdir[8] = '{8'hd5, 8'hff, 8'h55, 8'h7f, 8'h80, 8'h00, 8'haa, 8'h2a};
   // model of the held outputs, fed from a queue of expected results
   logic [7:0] exp_code = CODE_RST;
   logic [12:0] exp_lin = LIN_RST;
   logic [7:0] code_q[$];
   logic [12:0] lin_q[$];
   always #5 clk = ~clk;
   vcc_frame_src i_vcc_frame_src (.clk(clk), .rst(rst), .fire(fire), .fsync(fsync));
   vcc_codec i_vcc_codec (.clk(clk), .rst(rst), .law_select_pin(law), .power_down_input(pwr),
      .transmit_frame_sync(fsync), .tx_linear(lin), .rx_linear(rx_lin), .rx_valid(rx_valid),
      .rx_code(code), .tx_code(tx_code), .tx_valid(tx_valid));
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // compression: mu works on the doubled scale with bias, a on ones' complement
   function automatic logic [7:0] enc(bit mu, int x);
      int m, s, k;
      s = 0;
      k = (x < 0) ? (mu ? 8'h7f : 8'h55) : (mu ? 8'hff : 8'hd5);
      m = mu ? ((x < 0) ? -2 * x : 2 * x) : ((x < 0) ? -x - 1 : x);
      if (mu && m > 8158) m = 8158;
      if (mu) m = m + 33;
      for (int i = 0; i < 7; i++) if (m >= ((mu ? 64 : 32) << i)) s = i + 1;
      m = m >> (mu ? s + 1 : ((s == 0) ? 1 : s));
      return 8'(((s << 4) | (m & 15)) ^ k);
   endfunction
   // expansion to the step midpoint, then down to 13 bits
   function automatic logic [12:0] dec(bit mu, logic [7:0] c);
      int u, t, s;
      u = mu ? int'(~c) : int'(c ^ 8'h55);
      s = (u >> 4) & 7;
      if (mu) return 13'((((u & 128) != 0) ? 132 - ((((u & 15) << 3) + 132) << s)
         : ((((u & 15) << 3) + 132) << s) - 132) >>> 3);
      t = ((u & 15) << 4) + ((s == 0) ? 8 : 264);
      if (s > 1) t = t << (s - 1);
      t = t >>> 3;
      return 13'(((u & 128) != 0) ? t : -t);
   endfunction
   task automatic chk(logic [12:0] got, logic [12:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_code(logic [7:0] got, logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: code %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(logic [3:0] got, logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: count %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one frame: load inputs, pulse sync, count result pulses in a fixed window
   task automatic frame(bit on, int x, logic [7:0] c);
      int n;
      n = 0;
      @(posedge clk);
      lin <= 13'(x);
      code <= c;
      fire <= 1'b1;
      if (on) begin
         code_q.push_back(enc(law, x));
         lin_q.push_back(dec(law, c));
      end
      @(posedge clk);
      fire <= 1'b0;
      repeat (14) begin
         @(posedge clk);
         #1;
         if (tx_valid === 1'b1 || rx_valid === 1'b1) begin
            n++;
            chk_cnt({3'h0, tx_valid}, {3'h0, rx_valid});
            if (code_q.size() > 0) begin
               exp_code = code_q.pop_front();
               exp_lin = lin_q.pop_front();
            end
         end
      end
      chk_cnt(4'(n), {3'h0, on});
      chk_code(tx_code, exp_code);
      chk(rx_lin, exp_lin);
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      chk_code(tx_code, CODE_RST);
      chk(rx_lin, LIN_RST);
      for (int l = 0; l < 2; l++) begin
         @(posedge clk);
         law <= l[0];
         pwr <= 1'b0;
         repeat (4) @(posedge clk);
         frame(1'b0, 100, 8'h3c);
         @(posedge clk);
         pwr <= 1'b1;
         repeat (4) @(posedge clk);
         frame(1'b0, 200, 8'h11);
         frame(1'b0, 300, 8'h22);
         for (int k = 0; k < 8; k++) frame(1'b1, dir[k], cdir[k]);
         for (int k = 0; k < 40; k++) frame(1'b1, (xs() & 8191) - 4096, 8'(xs()));
      end
      final_report();
   end
endmodule
